// [tb/rpcd_host_model.sv]
// Purpose: Host model driving the serial command port.
// Assumes: Serial clock idles low, 160 ns period, free of core_clk.
// Notes: The serial clock stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module rpcd_host_model
(
	// Host pins
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	initial
	begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// Callers keep pipes 0 to 5, 0 to 32 bytes after the opcode, no clears in flight.
	task automatic run();
		logic [7:0] r;
		rxq = {};
		#3 spi_cs_n = 1'b0;
		#80;
		foreach (txq[i])
		begin
			for (int k = 7; k >= 0; k--)
			begin
				spi_mosi = txq[i][k];
				#80 spi_sck = 1'b1;
				r[k] = spi_miso_oe & spi_miso;
				#80 spi_sck = 1'b0;
			end
			rxq.push_back(r);
		end
		#160 spi_cs_n = 1'b1;
		// A released line must not keep showing the last bit.
		spi_mosi = ~spi_mosi;
		#400;
	endtask
endmodule
`default_nettype wire

// [tb/rpcd_top_sva.sv]
// Purpose: Port checker of the payload command decoder.
// Assumes: One clock domain, reset async high.
// Notes: Bound to every rpcd_top below.
`timescale 1ns/10ps
`default_nettype none
module rpcd_top_sva
#(
	parameter int DEPTH = 3
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic spi_cs_n,
	input wire logic spi_miso_oe,
	input wire logic primary_transmitter_role,
	input wire logic repeat_last_send,
	input wire rpcd_pkg::rpcd_txd_t txd,
	input wire logic send_without_reply_done,
	input wire logic [rpcd_pkg::LEN_W-1:0] send_len,
	input wire logic rx_clear,
	input wire logic ack_pop,
	input wire logic [$clog2(DEPTH+1)-1:0] ack_count
);
	import rpcd_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	a_oe_frame: assert property (!spi_cs_n [*6] |-> spi_miso_oe)
		else $error("miso not driven in frame");
	a_count_max: assert property (ack_count <= DEPTH)
		else $error("pending count over depth");
	a_count_step: assert property (ack_count > $past(ack_count) |->
		spi_cs_n && ack_count == $past(ack_count) + 1'b1) else $error("bad count step");
	a_pop_only: assert property (ack_count < $past(ack_count) |-> $past(ack_pop))
		else $error("count fell without pop");
	a_txd_role: assert property (txd.valid |-> primary_transmitter_role ##1 !txd.valid)
		else $error("bad send byte pulse");
	a_done_len: assert property (send_without_reply_done |-> send_len inside {[1:32]})
		else $error("bad send length");
	a_clear_role: assert property (rx_clear |-> !primary_transmitter_role ##1 !rx_clear)
		else $error("bad receive clear");
	a_repeat_frame: assert property ($changed(repeat_last_send) |-> spi_miso_oe)
		else $error("repeat changed outside frame");
endmodule
bind rpcd_top rpcd_top_sva #(.DEPTH(DEPTH)) chk_u (
	.core_clk(core_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
	.primary_transmitter_role(primary_transmitter_role), .repeat_last_send(repeat_last_send),
	.txd(txd), .send_without_reply_done(send_without_reply_done), .send_len(send_len),
	.rx_clear(rx_clear), .ack_pop(ack_pop), .ack_count(ack_count));
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench of the payload command decoder.
// Assumes: Host model drives the serial pins.
// Notes: Send bytes are noted in a queue and matched by a watcher.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import rpcd_pkg::*;
	logic core_clk, sys_rst, role, ack_pop, ready, rep, done, clr, sck, cs_n, mosi, miso, oe;
	logic [7:0] status, width, adata;
	logic [2:0] pipe;
	logic [IDX_W-1:0] idx;
	logic [LEN_W-1:0] slen, alen;
	logic [1:0] count;
	rpcd_txd_t txd;
	logic [15:0] exp_q[$];
	logic [7:0] pl[3][$];
	int err_count, checked, clears, c;
	int pipes[4] = '{2, 2, 5, 0};
	int lens[3] = '{1, 0, 32};
	logic [7:0] ops[3] = '{OP_SEND_PAYLOAD, OP_CLEAR_TRANSMIT, OP_SEND_WITHOUT_REPLY};
	rpcd_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .spi_sck(sck), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .primary_transmitter_role(role),
		.status_byte(status), .rx_head_width(width), .repeat_last_send(rep), .txd(txd),
		.send_without_reply_done(done), .send_len(slen), .rx_clear(clr), .ack_pipe(pipe),
		.ack_rd_idx(idx), .ack_pop(ack_pop), .ack_ready(ready), .ack_len(alen),
		.ack_data(adata), .ack_count(count));
	rpcd_host_model host_u (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.spi_miso_oe(oe));
	task automatic check(string name, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic close_out();
		$display("Checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic frame(logic [7:0] op, int n);
		host_u.txq = {op};
		repeat (n) host_u.txq.push_back(8'($urandom));
		if (op == OP_SEND_WITHOUT_REPLY && role)
		begin
			for (int k = 0; k < n; k++)
				exp_q.push_back({3'b000, 5'(k), host_u.txq[k + 1]});
			if (n > 0)
				exp_q.push_back({10'h200, 6'(n)});
		end
		host_u.run();
	endtask
	task automatic cmp(int e);
		for (int k = 0; k < pl[e].size(); k++)
		begin
			@(negedge core_clk);
			pipe = 3'(pipes[e]);
			idx = 5'(k);
			@(negedge core_clk);
			check("ack entry", {1'b1, 6'(pl[e].size()), pl[e][k]}, {ready, alen, adata});
		end
	endtask
	// Pulses are read mid-cycle, away from the edge that launches them.
	always @(negedge core_clk)
	begin
		if (clr === 1'b1)
			clears++;
		if (txd.valid === 1'b1 || done === 1'b1)
			check("send", exp_q.size() ? exp_q.pop_front() : 16'hxxxx,
				txd.valid ? {3'b000, txd.index, txd.data} : {10'h200, slen});
	end
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#400000;
		err_count++;
		close_out();
	end
	initial
	begin
		sys_rst = 1'b1;
		role = 1'b1;
		status = 8'h00;
		width = 8'h00;
		pipe = 3'h0;
		idx = 5'h00;
		ack_pop = 1'b0;
		void'($urandom(95614));
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge core_clk);
		status = 8'($urandom);
		width = 8'($urandom_range(32, 1));
		host_u.txq = {OP_READ_RECEIVE_WIDTH, OP_IDLE_COMMAND};
		host_u.run();
		check("status", {8'h00, status}, {8'h00, host_u.rxq[0]});
		check("width", {8'h00, width}, {8'h00, host_u.rxq[1]});
		foreach (ops[i])
		begin
			frame(OP_REPEAT_LAST_SEND, 0);
			frame(OP_IDLE_COMMAND, 0);
			check("repeat on", 16'h0001, 16'(rep));
			frame(ops[i], lens[i]);
			check("repeat off", 16'h0000, 16'(rep));
		end
		frame(OP_SEND_WITHOUT_REPLY, $urandom_range(31, 1));
		c = clears;
		frame(OP_CLEAR_RECEIVE, 0);
		@(negedge core_clk) role = 1'b0;
		frame(OP_CLEAR_RECEIVE, 0);
		frame(OP_SEND_WITHOUT_REPLY, 3);
		check("clears", 16'(c + 1), 16'(clears));
		foreach (pipes[i])
		begin
			frame({OP_ACK_LOAD_HI, 3'(pipes[i])}, i == 0 ? $urandom_range(32, 2) : i);
			if (i < 3)
				pl[i] = host_u.txq[1:$];
		end
		check("count", 16'h0003, 16'(count));
		cmp(0);
		cmp(2);
		@(negedge core_clk) pipe = 3'h2;
		@(negedge core_clk) ack_pop = 1'b1;
		@(negedge core_clk) ack_pop = 1'b0;
		pipe = 3'h0;
		@(negedge core_clk);
		check("count pop", 16'h0002, 16'(count));
		check("pipe empty", 16'h0000, 16'(ready));
		cmp(1);
		check("notes left", 16'h0000, 16'(exp_q.size()));
		close_out();
	end
endmodule
`default_nettype wire

// [verilog/rpcd_pkg.sv]
// Purpose: Shared constants and carriers of the radio payload command decoder.
// Assumes: Commands arrive as whole bytes, opcode first, most significant bit first.
// Notes: Opcodes are eight bits; the pipe select sits in the low three bits.
package rpcd_pkg;
	localparam logic [7:0] OP_REPEAT_LAST_SEND = 8'he3;
	localparam logic [7:0] OP_READ_RECEIVE_WIDTH = 8'h60;
	localparam logic [4:0] OP_ACK_LOAD_HI = 5'h15;
	localparam logic [7:0] OP_SEND_WITHOUT_REPLY = 8'hb0;
	localparam logic [7:0] OP_IDLE_COMMAND = 8'hff;
	localparam logic [7:0] OP_CLEAR_RECEIVE = 8'he2;
	localparam logic [7:0] OP_CLEAR_TRANSMIT = 8'he1;
	localparam logic [7:0] OP_SEND_PAYLOAD = 8'ha0;
	localparam int ACK_DEPTH = 3;
	localparam int PAYLOAD_MAX = 32;
	localparam int IDX_W = 5;
	localparam int LEN_W = 6;
	localparam logic [7:0] RESP_RESET = 8'h00;

	typedef struct packed {
		logic valid;
		logic first;
		logic [7:0] data;
	} rpcd_evt_t;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] index;
		logic [7:0] data;
	} rpcd_txd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK = 2'b01,
		ST_SEND = 2'b10,
		ST_SKIP = 2'b11
	} rpcd_state_t;
endpackage

// [verilog/rpcd_spi_port.sv]
// Purpose: Serial byte port: synchronises the host pins and frames bytes.
// Assumes: Clock idles low, data sampled on rising and shifted on falling edges.
// Notes: The serial clock is sampled, so it must stay well below core_clk / 4.
`timescale 1ns/10ps
`default_nettype none
module rpcd_spi_port
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Host pins
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Byte side
	input wire logic [7:0] first_byte,
	input wire logic [7:0] next_byte,
	output rpcd_pkg::rpcd_evt_t evt,
	output logic frame_start,
	output logic frame_end
);
	import rpcd_pkg::*;
	logic [2:0] sy1_r;
	logic [2:0] sy2_r;
	logic [1:0] sy3_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic first_r;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sy1_r <= 3'h2;
			sy2_r <= 3'h2;
			sy3_r <= 2'h1;
		end
		else
		begin
			sy1_r <= {spi_sck, spi_cs_n, spi_mosi};
			sy2_r <= sy1_r;
			sy3_r <= sy2_r[2:1];
		end
	end

	assign sck_rise = sy2_r[2] & ~sy3_r[1];
	assign sck_fall = ~sy2_r[2] & sy3_r[1];
	assign cs_fall = ~sy2_r[1] & sy3_r[0];
	assign cs_rise = sy2_r[1] & ~sy3_r[0];

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 8'h00;
			first_r <= 1'b0;
			evt <= '0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
		end
		else
		begin
			evt.valid <= 1'b0;
			frame_start <= cs_fall;
			frame_end <= cs_rise;
			if (cs_fall)
			begin
				bit_cnt_r <= 3'h0;
				first_r <= 1'b1;
			end
			else if (!sy2_r[1] && sck_rise)
			begin
				rx_sh_r <= {rx_sh_r[6:0], sy2_r[0]};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7)
				begin
					evt.valid <= 1'b1;
					evt.first <= first_r;
					evt.data <= {rx_sh_r[6:0], sy2_r[0]};
					first_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_sh_r <= 8'h00;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end
		else if (cs_fall)
		begin
			tx_sh_r <= first_byte;
			spi_miso <= first_byte[7];
			spi_miso_oe <= 1'b1;
		end
		else if (cs_rise)
		begin
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end
		else if (!sy2_r[1] && sck_fall)
		begin
			if (bit_cnt_r == 3'h0)
			begin
				tx_sh_r <= next_byte;
				spi_miso <= next_byte[7];
			end
			else
			begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
				spi_miso <= tx_sh_r[6];
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/rpcd_top.sv]
// Purpose: Payload command decoder of a packet radio serial port.
// Assumes: Packet engine and queues share core_clk with this block.
// Notes: Pending reply payloads live here; the receive and send queues do not.
// How it works
// - Repeat opcode in transmitter role sets repetition.
// - Repetition lasts until send write or transmit clear.
// - Width opcode returns head receive width byte.
// - Receive role loads reply payload for pipe.
// - Up to three reply payloads pending.
// - Same pipe payloads leave oldest first.
// - One to thirty-two bytes, low byte first.
// - Every load starts at byte zero.
// - Transmitter send opcode queues payload without reply.
// - Idle opcode changes nothing, status still returned.
// - Receive role clear opcode empties receive queue.
`timescale 1ns/10ps
`default_nettype none
module rpcd_top
#(
	parameter int DEPTH = rpcd_pkg::ACK_DEPTH
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Host serial port
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Device state
	input wire logic primary_transmitter_role,
	input wire logic [7:0] status_byte,
	input wire logic [7:0] rx_head_width,
	// Transmit side and receive clear
	output logic repeat_last_send,
	output rpcd_pkg::rpcd_txd_t txd,
	output logic send_without_reply_done,
	output logic [rpcd_pkg::LEN_W-1:0] send_len,
	output logic rx_clear,
	// Reply payload read port
	input wire logic [2:0] ack_pipe,
	input wire logic [rpcd_pkg::IDX_W-1:0] ack_rd_idx,
	input wire logic ack_pop,
	output logic ack_ready,
	output logic [rpcd_pkg::LEN_W-1:0] ack_len,
	output logic [7:0] ack_data,
	output logic [$clog2(DEPTH+1)-1:0] ack_count
);
	import rpcd_pkg::*;
	localparam int CW = $clog2(DEPTH+1);
	localparam int SW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(PAYLOAD_MAX);

	rpcd_evt_t evt;
	logic frame_start;
	logic frame_end;
	rpcd_state_t st_r;
	logic [7:0] resp_r;
	logic [7:0] stat_r;
	logic repeat_r;
	rpcd_txd_t txd_r;
	logic done_r;
	logic clear_r;
	logic [LEN_W-1:0] idx_r;
	logic [LEN_W-1:0] send_len_r;
	logic [2:0] ld_pipe_r;
	logic [CW-1:0] cnt_r;
	logic [2:0] pipe_r [DEPTH];
	logic [LEN_W-1:0] len_r [DEPTH];
	logic [7:0] buf_r [DEPTH][PAYLOAD_MAX];
	logic ready_r;
	logic [LEN_W-1:0] alen_r;
	logic [7:0] adata_r;
	logic [SW:0] hit;
	logic pop_go;
	logic commit;
	logic [CW-1:0] slot;

	// Lowest slot holding the pipe is its oldest payload, since slots stay in write order.
	function automatic logic [SW:0] find_oldest(input logic [2:0] p, input logic [CW-1:0] n);
		logic [SW:0] r;
		r = '0;
		for (int j = DEPTH - 1; j >= 0; j--)
		begin
			if (CW'(j) < n && pipe_r[j] == p)
			begin
				r = {1'b1, SW'(j)};
			end
		end
		return r;
	endfunction

	rpcd_spi_port u_port
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.first_byte(stat_r),
		.next_byte(resp_r),
		.evt(evt),
		.frame_start(frame_start),
		.frame_end(frame_end)
	);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stat_r <= 8'h00;
		end
		else
		begin
			stat_r <= status_byte;
		end
	end

	assign hit = find_oldest(ack_pipe, cnt_r);
	assign pop_go = ack_pop & hit[SW];
	assign commit = frame_end && st_r == ST_ACK && idx_r != '0;
	assign slot = pop_go ? cnt_r - CW'(1) : cnt_r;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= ST_IDLE;
			resp_r <= RESP_RESET;
			ld_pipe_r <= 3'h0;
			idx_r <= '0;
		end
		else if (frame_start || frame_end)
		begin
			st_r <= ST_IDLE;
			resp_r <= RESP_RESET;
			idx_r <= '0;
		end
		else if (evt.valid && evt.first)
		begin
			resp_r <= RESP_RESET;
			st_r <= ST_SKIP;
			idx_r <= '0;
			if (evt.data == OP_READ_RECEIVE_WIDTH)
			begin
				resp_r <= rx_head_width;
			end
			else if (evt.data[7:3] == OP_ACK_LOAD_HI && !primary_transmitter_role)
			begin
				if (cnt_r < CW'(DEPTH) || pop_go)
				begin
					st_r <= ST_ACK;
				end
				ld_pipe_r <= evt.data[2:0];
			end
			else if (evt.data == OP_SEND_WITHOUT_REPLY && primary_transmitter_role)
			begin
				st_r <= ST_SEND;
			end
		end
		else if (evt.valid)
		begin
			resp_r <= RESP_RESET;
			if ((st_r == ST_ACK || st_r == ST_SEND) && idx_r < LEN_MAX)
			begin
				idx_r <= idx_r + LEN_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			repeat_r <= 1'b0;
			clear_r <= 1'b0;
		end
		else
		begin
			clear_r <= 1'b0;
			if (evt.valid && evt.first)
			begin
				case (evt.data)
					OP_REPEAT_LAST_SEND:
					begin
						if (primary_transmitter_role)
						begin
							repeat_r <= 1'b1;
						end
					end
					OP_SEND_PAYLOAD, OP_SEND_WITHOUT_REPLY, OP_CLEAR_TRANSMIT:
					begin
						repeat_r <= 1'b0;
					end
					OP_CLEAR_RECEIVE:
					begin
						clear_r <= ~primary_transmitter_role;
					end
					OP_IDLE_COMMAND:
					begin
						repeat_r <= repeat_r;
					end
					default:
					begin
						repeat_r <= repeat_r;
					end
				endcase
			end
		end
	end

	// Each of the first 32 data bytes is streamed out at once; the queue behind decides where it lands.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			txd_r <= '0;
			done_r <= 1'b0;
			send_len_r <= '0;
		end
		else
		begin
			txd_r.valid <= 1'b0;
			done_r <= frame_end && st_r == ST_SEND && idx_r != '0;
			if (frame_end)
			begin
				send_len_r <= idx_r;
			end
			if (evt.valid && !evt.first && st_r == ST_SEND && idx_r < LEN_MAX)
			begin
				txd_r.valid <= 1'b1;
				txd_r.index <= idx_r[IDX_W-1:0];
				txd_r.data <= evt.data;
			end
		end
	end

	// A pop while a load is open shifts the open slot down together with the rest.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_r <= '0;
			pipe_r <= '{default: '0};
			len_r <= '{default: '0};
			buf_r <= '{default: '{default: '0}};
		end
		else
		begin
			if (pop_go)
			begin
				for (int j = 0; j < DEPTH - 1; j++)
				begin
					if (SW'(j) >= hit[SW-1:0])
					begin
						pipe_r[j] <= pipe_r[j+1];
						len_r[j] <= len_r[j+1];
						buf_r[j] <= buf_r[j+1];
					end
				end
			end
			if (evt.valid && !evt.first && st_r == ST_ACK && idx_r < LEN_MAX)
			begin
				buf_r[slot[SW-1:0]][idx_r[IDX_W-1:0]] <= evt.data;
			end
			if (commit)
			begin
				pipe_r[slot[SW-1:0]] <= ld_pipe_r;
				len_r[slot[SW-1:0]] <= idx_r;
			end
			cnt_r <= cnt_r - CW'(pop_go) + CW'(commit);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ready_r <= 1'b0;
			alen_r <= '0;
			adata_r <= 8'h00;
		end
		else
		begin
			ready_r <= hit[SW];
			alen_r <= len_r[hit[SW-1:0]];
			adata_r <= buf_r[hit[SW-1:0]][ack_rd_idx];
		end
	end

	assign repeat_last_send = repeat_r;
	assign txd = txd_r;
	assign send_without_reply_done = done_r;
	assign send_len = send_len_r;
	assign rx_clear = clear_r;
	assign ack_ready = ready_r;
	assign ack_len = alen_r;
	assign ack_data = adata_r;
	assign ack_count = cnt_r;
endmodule
`default_nettype wire
